// ===== i2c_bit_pkg.sv
package i2c_bit_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] IRQ_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] BIT_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h08;

  // field positions
  localparam int IRQ_PEND_BIT = 0;
  localparam int DATA_BIT     = 0;
  localparam int RBD_BIT      = 0;
  localparam int WBD_BIT      = 1;
  localparam int CRS_BIT      = 2;
  localparam int BUSY_BIT     = 3;
  localparam int ARB_BIT      = 4;
  localparam int MASTER_BIT   = 5;
  localparam int SWSCL_BIT    = 6;
  localparam int RESUME_BIT   = 7;

  // reset values
  localparam logic DRV_RST    = 1'b1;
  localparam logic MASTER_RST = 1'b0;

  // timing
  localparam int CNT_W     = 8;
  localparam int CLK_NS    = 40;
  localparam int T_LOW_NS  = 4700;
  localparam int T_HIGH_NS = 4000;
  localparam int LOW_CYC_I  = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_CYC_I = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [CNT_W-1:0] LOW_CYC  = CNT_W'(LOW_CYC_I);
  localparam logic [CNT_W-1:0] HIGH_CYC = CNT_W'(HIGH_CYC_I);

  // line events crossing from the link domain
  localparam int NEV = 4;
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } link_ev_t;

  // status flags, packed in register bit order
  typedef struct packed {
    logic arb_lost;
    logic bus_occupied;
    logic clock_rise_seen;
    logic write_bit_done;
    logic read_bit_done;
  } flags_t;

  typedef enum logic [2:0] {
    AC_IDLE,
    AC_LOW,
    AC_WAIT_RISE,
    AC_HIGH,
    AC_HOLD
  } auto_clk_t;

endpackage

// ===== bit_level_i2c_port.sv
module bit_level_i2c_port #(
  parameter logic [i2c_bit_pkg::CNT_W-1:0] LOW_CYC  = i2c_bit_pkg::LOW_CYC,
  parameter logic [i2c_bit_pkg::CNT_W-1:0] HIGH_CYC = i2c_bit_pkg::HIGH_CYC
) (
  // apb slave
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [i2c_bit_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [i2c_bit_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                       pstrb,
  output logic      [i2c_bit_pkg::DATA_W-1:0]   prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // two-wire link
  input  wire logic                             link_clk,
  input  wire logic                             scl_i,
  input  wire logic                             sda_i,
  output logic                                  scl_o,
  output logic                                  scl_oe,
  output logic                                  sda_o,
  output logic                                  sda_oe
);
  import i2c_bit_pkg::*;

  // link domain reset, released on the link clock
  logic [1:0] lrst_sync;
  logic       lrst_n;

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      lrst_sync <= 2'h0;
    end else begin
      lrst_sync <= {lrst_sync[0], 1'b1};
    end
  end
  assign lrst_n = lrst_sync[1];

  // link domain: pin sync, glitch filter, condition detect
  logic [2:0]     scl_sy;
  logic [2:0]     sda_sy;
  logic           scl_f;
  logic           sda_f;
  logic           scl_q;
  logic           sda_q;
  logic           sda_at_rise;
  link_ev_t       ev_c;
  link_ev_t       ev_tgl;
  wire logic      next_scl_f;
  wire logic      next_sda_f;

  // a change counts only once two stages agree
  assign next_scl_f = (scl_sy[1] == scl_sy[2]) ? scl_sy[2] : scl_f;
  assign next_sda_f = (sda_sy[1] == sda_sy[2]) ? sda_sy[2] : sda_f;

  assign ev_c.start = sda_q & ~sda_f & scl_q & scl_f;
  assign ev_c.stop  = ~sda_q & sda_f & scl_q & scl_f;
  assign ev_c.rise  = ~scl_q & scl_f;
  assign ev_c.fall  = scl_q & ~scl_f;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      scl_f  <= 1'b1;
      sda_f  <= 1'b1;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[1:0], scl_i};
      sda_sy <= {sda_sy[1:0], sda_i};
      scl_f  <= next_scl_f;
      sda_f  <= next_sda_f;
      scl_q  <= scl_f;
      sda_q  <= sda_f;
    end
  end

  // events leave as toggles; the bit word is stable long before
  // the next rise, so it is read only after its toggle lands
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ev_tgl      <= '0;
      sda_at_rise <= 1'b1;
    end else begin
      ev_tgl      <= ev_tgl ^ ev_c;
      if (ev_c.rise) begin
        sda_at_rise <= sda_f;
      end
    end
  end

  // bus domain: event toggle crossings
  logic [NEV-1:0] ev_p_v;
  link_ev_t       ev_p;

  genvar g;
  generate
    for (g = 0; g < NEV; g++) begin : g_ev
      logic [2:0] sy;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sy <= 3'h0;
        end else begin
          sy <= {sy[1:0], ev_tgl[g]};
        end
      end
      assign ev_p_v[g] = sy[2] ^ sy[1];
    end
  endgenerate
  assign ev_p = link_ev_t'(ev_p_v);

  // register access decode
  logic           irq;
  logic           armed;
  logic           sampled;
  logic           driven;
  logic           master;
  logic           swscl;
  logic           stretch;
  flags_t         flags;
  auto_clk_t      ac_st;
  logic [CNT_W-1:0] ac_cnt;

  wire logic      acc;
  wire logic      wr_ok;
  wire logic      hit_irq;
  wire logic      hit_bit;
  wire logic      hit_ctrl;
  wire logic      hit_any;
  wire logic      irq_wr;
  wire logic      bit_wr;
  wire logic      ctrl_wr;
  wire logic      resume;
  wire logic      arb_now;
  wire logic [DATA_W-1:0] irq_rd;
  wire logic [DATA_W-1:0] bit_rd;
  wire logic [DATA_W-1:0] ctrl_rd;
  wire logic [DATA_W-1:0] rd_mux;

  assign acc      = psel & penable & pready;
  // all fields sit in byte 0, so only its strobe gates a write
  assign wr_ok    = acc & pwrite & pstrb[0];
  assign hit_irq  = paddr == IRQ_OFS;
  assign hit_bit  = paddr == BIT_OFS;
  assign hit_ctrl = paddr == CTRL_OFS;
  assign hit_any  = hit_irq | hit_bit | hit_ctrl;
  assign irq_wr   = wr_ok & hit_irq;
  assign bit_wr   = wr_ok & hit_bit;
  assign ctrl_wr  = wr_ok & hit_ctrl;

  // either a data bit write or the resume bit continues the transfer
  assign resume   = bit_wr | (ctrl_wr & pwdata[RESUME_BIT]);
  // data seen low while our bit released the line
  assign arb_now  = ev_p.rise & driven & ~sda_at_rise;

  assign irq_rd  = DATA_W'(irq) << IRQ_PEND_BIT;
  assign bit_rd  = DATA_W'(sampled) << DATA_BIT;
  assign ctrl_rd = DATA_W'(flags)
                 | (DATA_W'(master) << MASTER_BIT)
                 | (DATA_W'(swscl) << SWSCL_BIT);
  assign rd_mux  = hit_irq  ? irq_rd  :
                   hit_bit  ? bit_rd  :
                   hit_ctrl ? ctrl_rd : '0;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_any;
      // taken a cycle early so that it stands beside pready
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // software written controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      driven <= DRV_RST;
      master <= MASTER_RST;
      swscl  <= 1'b0;
    end else begin
      if (bit_wr) begin
        driven <= pwdata[DATA_BIT];
      end
      if (ctrl_wr) begin
        master <= pwdata[MASTER_BIT];
        swscl  <= pwdata[SWSCL_BIT];
      end
    end
  end

  // flags: a hardware set wins over a same-cycle clear
  flags_t    next_flags;
  wire logic next_irq;
  wire logic next_armed;
  wire logic next_stretch;

  assign next_flags.read_bit_done =
    ev_p.fall | (flags.read_bit_done & ~resume);
  assign next_flags.write_bit_done =
    (ev_p.fall & ~flags.arb_lost)
    | (flags.write_bit_done & ~resume);
  assign next_flags.clock_rise_seen =
    ev_p.rise | (flags.clock_rise_seen & ~resume);
  assign next_flags.bus_occupied =
    ev_p.start | (flags.bus_occupied & ~ev_p.stop);
  assign next_flags.arb_lost =
    arb_now | (flags.arb_lost & ~resume);

  assign next_armed   = ev_p.start | (armed & ~ev_p.fall);
  assign next_irq     = (armed & ev_p.fall)
                      | (irq & ~(irq_wr & pwdata[IRQ_PEND_BIT]));
  // every fall stretches, busy or not, so no bit slips past software
  assign next_stretch = ev_p.fall | (stretch & ~resume);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags   <= '0;
      armed   <= 1'b0;
      irq     <= 1'b0;
      stretch <= 1'b0;
      sampled <= 1'b1;
    end else begin
      flags   <= next_flags;
      armed   <= next_armed;
      irq     <= next_irq;
      stretch <= next_stretch;
      if (ev_p.rise) begin
        sampled <= sda_at_rise;
      end
    end
  end

  // automatic clock pulse in master mode
  auto_clk_t        next_ac_st;
  logic [CNT_W-1:0] next_ac_cnt;
  wire logic        ac_low;

  always_comb begin
    next_ac_st  = ac_st;
    next_ac_cnt = ac_cnt;
    case (ac_st)
      AC_IDLE: begin
        // with master clear a data write only resumes
        if (bit_wr & master) begin
          next_ac_st  = AC_LOW;
          next_ac_cnt = LOW_CYC - 1'b1;
        end
      end
      AC_LOW: begin
        if (ac_cnt == '0) begin
          next_ac_st = AC_WAIT_RISE;
        end else begin
          next_ac_cnt = ac_cnt - 1'b1;
        end
      end
      AC_WAIT_RISE: begin
        // a slave may still be stretching; count from the seen rise
        if (ev_p.rise) begin
          next_ac_st  = AC_HIGH;
          next_ac_cnt = HIGH_CYC - 1'b1;
        end
      end
      AC_HIGH: begin
        if (ac_cnt == '0) begin
          next_ac_st = AC_HOLD;
        end else begin
          next_ac_cnt = ac_cnt - 1'b1;
        end
      end
      AC_HOLD: begin
        // keep the line low until the stretch takes over
        if (ev_p.fall) begin
          next_ac_st = AC_IDLE;
        end
      end
      default: begin
        next_ac_st = AC_IDLE;
      end
    endcase
  end

  assign ac_low = (ac_st == AC_LOW) | (ac_st == AC_HOLD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_st  <= AC_IDLE;
      ac_cnt <= '0;
    end else begin
      ac_st  <= next_ac_st;
      ac_cnt <= next_ac_cnt;
    end
  end

  // a held clock stays held until the data drive has followed the
  // driven bit, so data never moves with the released clock edge
  wire logic sda_settling;

  assign sda_settling = sda_oe ^ ~driven;

  // open-drain drivers: pull low or release only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      scl_oe <= stretch | ac_low | swscl | (scl_oe & sda_settling);
      sda_oe <= ~driven;
    end
  end

endmodule

// ===== bit_level_i2c_port_properties.sv
module i2c_port_checker
  import i2c_bit_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOW_CYC  = 8'h04,
  parameter logic [CNT_W-1:0] HIGH_CYC = 8'h04
) (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // line side
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       done;
  logic       unmapped;
  logic [7:0] since_wr;
  logic [7:0] hi_cnt;
  assign done     = psel && penable && pready;
  assign unmapped = !(paddr inside {IRQ_OFS, BIT_OFS, CTRL_OFS});
  // saturating, so long quiet spells never wrap back into range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_wr <= 8'hff;
      hi_cnt   <= 8'h00;
    end else begin
      since_wr <= (done && pwrite) ? 8'h00
                  : since_wr + {7'h0, since_wr != 8'hff};
      hi_cnt   <= scl_i ? hi_cnt + {7'h0, hi_cnt != 8'hff} : 8'h00;
    end
  end
  a_drive_low_only: assert property (!scl_o && !sda_o)
    else $error("line output driven high");
  a_ready_one_wait: assert property (
    psel && penable && !$past(penable) |=> pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_error_unmapped: assert property (done |-> pslverr == unmapped)
    else $error("pslverr does not match address decode");
  a_error_data_zero: assert property (
    done && unmapped && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_unused_bits_zero: assert property (
    done && !pwrite |-> prdata[31:7] == 25'h0
    && (paddr == CTRL_OFS || prdata[6:1] == 6'h0))
    else $error("unused read bits not zero");
  a_stretch_until_write: assert property (
    $fell(scl_oe) |-> since_wr <= LOW_CYC + 8'h08)
    else $error("clock released without a resume");
  a_data_follows_write: assert property (
    $changed(sda_oe) |-> since_wr <= 8'h06)
    else $error("data drive changed without a write");
  a_auto_high_min: assert property (
    $rose(scl_oe) && $past(scl_i) |-> hi_cnt >= HIGH_CYC)
    else $error("automatic clock high too short");
  c_unmapped: cover property (done && unmapped);
  c_auto_clock: cover property ($rose(scl_oe) && $past(scl_i));
  c_release: cover property ($fell(scl_oe));
endmodule

bind bit_level_i2c_port i2c_port_checker #(
  .LOW_CYC(LOW_CYC), .HIGH_CYC(HIGH_CYC)
) i_i2c_port_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_o(sda_o), .sda_oe(sda_oe)
);

// ===== two_wire_peer.sv
module two_wire_peer (
  // timing reference
  input  wire logic pclk,
  // device pull-downs
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // resolved wires
  output logic      scl_i,
  output logic      sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // pull-ups: released lines go high, any pull-down wins
  assign scl_i = !(scl_oe || scl_low);
  assign sda_i = !(sda_oe || sda_low);
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // data moves while clock is high: start or stop
  task automatic cond(input logic low);
    hold(120);
    sda_low <= low;
    hold(120);
  endtask
  // data only released while clock is low
  task automatic fall();
    hold(120);
    scl_low <= 1'b1;
    hold(60);
    sda_low <= 1'b0;
    hold(60);
    scl_low <= 1'b0;
    hold(120);
  endtask
endmodule

// ===== bit_level_i2c_port_tb.sv
module bit_level_i2c_port_tb import i2c_bit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk     = 1'b0;
  logic        link_clk = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [3:0]  pstrb    = 4'h0;
  logic        lo_strb  = 1'b1;
  wire  [31:0] prdata;
  wire         pready, pslverr, scl_i, sda_i, scl_o, scl_oe, sda_o, sda_oe;
  logic [65:0] q[$];
  logic [65:0] r;
  logic [11:0] row [6] = '{12'h50f, 12'h61d, 12'h00f,
                           12'hd2f, 12'h82f, 12'he3d};
  int          n_fail      = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  initial forever #20 pclk = ~pclk;
  initial begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  bit_level_i2c_port #(.LOW_CYC(8'h04), .HIGH_CYC(8'h04))
  i_bit_level_i2c_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
  two_wire_peer i_two_wire_peer (.pclk(pclk), .scl_oe(scl_oe),
    .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // expected {pslverr, prdata} and mask, noted at setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= {3'($urandom), lo_strb};
    q.push_back({e & m, m});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      r = q.pop_front();
      chk({pslverr, prdata} & r[32:0], r[65:33]);
    end
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    void'($urandom(59107));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(CTRL_OFS, 32'h0, 32'hffff_ffff);
    rd(BIT_OFS, 32'h1, 32'hffff_ffff);
    rd(IRQ_OFS, 32'h0, 32'hffff_ffff);
    apb(1'b0, 8'h0c, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
    apb(1'b1, 8'h0c, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    lo_strb = 1'b0;
    wr(CTRL_OFS, 32'h20);
    lo_strb = 1'b1;
    rd(CTRL_OFS, 32'h0, 32'hff);
    // software clock bit kept clear, it would pull the line
    wr(CTRL_OFS, ($urandom & 32'hffff_ff3f) | 32'h20);
    rd(CTRL_OFS, 32'h20, 32'hff);
    wr(CTRL_OFS, 32'h0);
    i_two_wire_peer.cond(1'b1);
    rd(CTRL_OFS, 32'h08, 32'h08);
    i_two_wire_peer.fall();
    rd(IRQ_OFS, 32'h1, 32'h1);
    chk({32'h0, scl_i}, 33'h0);
    wr(IRQ_OFS, 32'h1);
    rd(IRQ_OFS, 32'h0, 32'h1);
    // slave rx 1, rx 0 with loss, tx 0, then master tx/rx and loss
    for (int i = 0; i < 6; i++) begin
      wr(CTRL_OFS, {26'h0, row[i][11], 5'h0});
      i_two_wire_peer.sda_low <= row[i][9];
      wr(BIT_OFS, {31'h0, row[i][10]});
      rd(CTRL_OFS, 32'h0, 32'h03);
      if (row[i][11])
        i_two_wire_peer.hold(300);
      else
        i_two_wire_peer.fall();
      rd(CTRL_OFS, {24'h0, row[i][7:0]}, 32'hff);
      rd(BIT_OFS, {31'h0, row[i][8]}, 32'hffff_ffff);
      chk({32'h0, scl_i}, 33'h0);
      i_two_wire_peer.sda_low <= 1'b0;
    end
    rd(IRQ_OFS, 32'h0, 32'h1);
    i_two_wire_peer.sda_low <= 1'b1;
    wr(CTRL_OFS, 32'h80);
    i_two_wire_peer.cond(1'b0);
    rd(CTRL_OFS, 32'h0, 32'h08);
    // software low on the clock line, then released by a resume
    wr(CTRL_OFS, 32'h40);
    i_two_wire_peer.hold(60);
    chk({32'h0, scl_i}, 33'h0);
    rd(CTRL_OFS, 32'h41, 32'h49);
    wr(CTRL_OFS, 32'h80);
    i_two_wire_peer.hold(60);
    rd(CTRL_OFS, 32'h04, 32'h5f);
    results();
  end
endmodule
